/* File: pkg/ebcs_pkg.sv */
// Constants and types shared by the external bus chip select controller
package ebcs_pkg;

  // Number of decoded chip select areas
  localparam int EBCS_NUM_CS = 5;

  // Inclusive lower and upper bounds of each chip select area
  localparam logic [23:0] EBCS_CS_LO [EBCS_NUM_CS] = '{
    24'h000880, 24'h008000, 24'h040000, 24'h080000, 24'h0C0000
  };
  localparam logic [23:0] EBCS_CS_HI [EBCS_NUM_CS] = '{
    24'h007FFF, 24'h03FFFF, 24'h07FFFF, 24'h0BFFFF, 24'h0FFFFF
  };

  // Default internal memory area (registers and RAM)
  localparam logic [23:0] EBCS_INT_LO = 24'h000000;
  localparam logic [23:0] EBCS_INT_HI = 24'h00087F;

  // Start vector locations and fixed top byte
  localparam logic [23:0] EBCS_VEC_LO_ADDR = 24'h00FFFE;
  localparam logic [23:0] EBCS_VEC_HI_ADDR = 24'h00FFFF;
  localparam logic [7:0] EBCS_VEC_BANK = 8'h00;

  // Idle levels of the active low chip select outputs
  localparam logic [4:0] EBCS_CS_IDLE = 5'h1F;

  // Sequencer states
  typedef enum logic [2:0] {
    EBCS_IDLE = 3'b000,
    EBCS_VLO_ISSUE = 3'b001,
    EBCS_VLO_CAP = 3'b010,
    EBCS_VHI_ISSUE = 3'b011,
    EBCS_VHI_CAP = 3'b100,
    EBCS_RUN = 3'b101,
    EBCS_HALT = 3'b110
  } ebcs_state_e;

endpackage

/* File: hw/ebcs_ctrl.sv */
// External bus chip select, strobe gating and start vector sequencer
module ebcs_ctrl #(
  parameter logic [23:0] INT_LO = ebcs_pkg::EBCS_INT_LO,
  parameter logic [23:0] INT_HI = ebcs_pkg::EBCS_INT_HI
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic modeSelectPin,
  input wire logic byteModePin,
  input wire logic sigOutDisableBit,
  input wire logic standbySelBit,
  input wire logic busClkPortLatch,
  input wire logic busClkPortDir,
  input wire logic waitInstruction,
  input wire logic stopInstruction,
  input wire logic wakeUp,
  input wire logic accValid,
  input wire logic [23:0] accAddr,
  input wire logic accWrite,
  input wire logic accLoByte,
  input wire logic accHiByte,
  input wire logic [7:0] extReadData,
  output logic accReady,
  output logic chipSel0N,
  output logic chipSel1N,
  output logic chipSel2N,
  output logic chipSel3N,
  output logic chipSel4N,
  output logic readStrobeN,
  output logic writeStrobeLoN,
  output logic writeStrobeHiN,
  output logic busClkPinOut,
  output logic busClkPinOe,
  output logic [23:0] startAddr,
  output logic startValid,
  output logic procModeActive,
  output logic standbyActive
);

  ebcs_pkg::ebcs_state_e state_reg, state_next;
  logic [4:0] cs_reg, cs_next;
  logic rd_reg, rd_next;
  logic wl_reg, wl_next;
  logic wh_reg, wh_next;
  logic phi_reg, phi_next;
  logic stby_reg, stby_next;
  logic mode_reg, mode_next;
  logic [23:0] start_reg, start_next;
  logic issue;
  logic issueWrite;
  logic issueLo;
  logic issueHi;
  logic [23:0] issueAddr;
  logic isInternal;
  logic [4:0] inArea;

  // Internal area decode; chip selects never cover it
  assign isInternal = (issueAddr >= INT_LO) && (issueAddr <= INT_HI);

  // Per-area range compare
  genvar gi;
  generate
    for (gi = 0; gi < ebcs_pkg::EBCS_NUM_CS; gi++) begin : g_area
      assign inArea[gi] = (issueAddr >= ebcs_pkg::EBCS_CS_LO[gi]) &&
        (issueAddr <= ebcs_pkg::EBCS_CS_HI[gi]) && !isInternal;
    end
  endgenerate

  // Access source: vector fetch while starting, user requests when running
  always_comb begin
    issue = 1'b0;
    issueWrite = 1'b0;
    issueLo = 1'b1;
    issueHi = 1'b0;
    issueAddr = accAddr;
    accReady = (state_reg == ebcs_pkg::EBCS_RUN) && !stby_reg;
    case (state_reg)
      ebcs_pkg::EBCS_VLO_ISSUE: begin
        issue = 1'b1;
        issueAddr = ebcs_pkg::EBCS_VEC_LO_ADDR;
      end
      ebcs_pkg::EBCS_VHI_ISSUE: begin
        issue = 1'b1;
        issueAddr = ebcs_pkg::EBCS_VEC_HI_ADDR;
      end
      ebcs_pkg::EBCS_RUN: begin
        issue = accValid && !stby_reg;
        issueWrite = accWrite;
        issueLo = accLoByte || byteModePin;
        issueHi = accHiByte && !byteModePin;
      end
      default: begin
        issue = 1'b0;
      end
    endcase
  end

  // Sequencer next state; mode pin is caught on the first cycle after release
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    start_next = start_reg;
    stby_next = stby_reg;
    case (state_reg)
      ebcs_pkg::EBCS_IDLE: begin
        mode_next = modeSelectPin;
        state_next = modeSelectPin ? ebcs_pkg::EBCS_VLO_ISSUE :
          ebcs_pkg::EBCS_HALT;
      end
      ebcs_pkg::EBCS_VLO_ISSUE: state_next = ebcs_pkg::EBCS_VLO_CAP;
      ebcs_pkg::EBCS_VLO_CAP: begin
        start_next[7:0] = extReadData;
        state_next = ebcs_pkg::EBCS_VHI_ISSUE;
      end
      ebcs_pkg::EBCS_VHI_ISSUE: state_next = ebcs_pkg::EBCS_VHI_CAP;
      ebcs_pkg::EBCS_VHI_CAP: begin
        start_next[15:8] = extReadData;
        start_next[23:16] = ebcs_pkg::EBCS_VEC_BANK;
        state_next = ebcs_pkg::EBCS_RUN;
      end
      ebcs_pkg::EBCS_RUN: begin
        // Wake has priority so a late wake is not swallowed
        if (wakeUp) begin
          stby_next = 1'b0;
        end else if (waitInstruction || stopInstruction) begin
          stby_next = 1'b1;
        end
      end
      ebcs_pkg::EBCS_HALT: state_next = ebcs_pkg::EBCS_HALT;
      default: state_next = ebcs_pkg::EBCS_IDLE;
    endcase
  end

  // Pin levels for the cycle after an access is issued
  always_comb begin
    cs_next = ebcs_pkg::EBCS_CS_IDLE;
    rd_next = 1'b1;
    wl_next = 1'b1;
    wh_next = 1'b1;
    if (issue) begin
      cs_next = ~inArea;
      // Disabled outputs stay high on internal accesses
      if (!sigOutDisableBit || !isInternal) begin
        rd_next = issueWrite;
        wl_next = !(issueWrite && issueLo);
        wh_next = !(issueWrite && issueHi);
      end
    end else if (stby_next) begin
      // Low in standby only when software also picked the low level
      rd_next = !(sigOutDisableBit && standbySelBit);
    end
  end

  // Bus clock divider runs free; gating is done at the pin
  assign phi_next = ~phi_reg;

  // State registers; synchronous reset to constants only
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ebcs_pkg::EBCS_IDLE;
      cs_reg <= ebcs_pkg::EBCS_CS_IDLE;
      rd_reg <= 1'b1;
      wl_reg <= 1'b1;
      wh_reg <= 1'b1;
      phi_reg <= 1'b0;
      stby_reg <= 1'b0;
      mode_reg <= 1'b0;
      start_reg <= '0;
    end else begin
      state_reg <= state_next;
      cs_reg <= cs_next;
      rd_reg <= rd_next;
      wl_reg <= wl_next;
      wh_reg <= wh_next;
      phi_reg <= phi_next;
      stby_reg <= stby_next;
      mode_reg <= mode_next;
      start_reg <= start_next;
    end
  end

  // Pin outputs
  assign chipSel0N = cs_reg[0];
  assign chipSel1N = cs_reg[1];
  assign chipSel2N = cs_reg[2];
  assign chipSel3N = cs_reg[3];
  assign chipSel4N = cs_reg[4];
  assign readStrobeN = rd_reg;
  assign writeStrobeLoN = wl_reg;
  assign writeStrobeHiN = wh_reg;
  // Latch value only reaches the pin if direction is set to output
  assign busClkPinOut = sigOutDisableBit ? busClkPortLatch : phi_reg;
  assign busClkPinOe = sigOutDisableBit ? busClkPortDir : 1'b1;
  assign startAddr = start_reg;
  assign startValid = (state_reg == ebcs_pkg::EBCS_RUN);
  assign procModeActive = mode_reg;
  assign standbyActive = stby_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_cs0_area;
    issue && issueAddr >= ebcs_pkg::EBCS_CS_LO[0] &&
      issueAddr <= ebcs_pkg::EBCS_CS_HI[0] && !isInternal |=>
      !chipSel0N && chipSel1N;
  endproperty
  a_cs0_area: assert property (p_cs0_area)
    else $error("chip select 0 not low for its area");

  property p_cs1_area;
    issue && issueAddr >= ebcs_pkg::EBCS_CS_LO[1] &&
      issueAddr <= ebcs_pkg::EBCS_CS_HI[1] && !isInternal |=>
      !chipSel1N && chipSel0N && chipSel2N;
  endproperty
  a_cs1_area: assert property (p_cs1_area)
    else $error("chip select 1 not low for its area");

  property p_cs_banks;
    issue |=> (chipSel2N == !($past(issueAddr[23:18]) == 6'h01)) &&
      (chipSel3N == !($past(issueAddr[23:18]) == 6'h02)) &&
      (chipSel4N == !($past(issueAddr[23:18]) == 6'h03));
  endproperty
  a_cs_banks: assert property (p_cs_banks)
    else $error("upper bank chip select mismatch");

  property p_cs_idle;
    !issue || isInternal |=> chipSel0N && chipSel1N && chipSel2N &&
      chipSel3N && chipSel4N;
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("chip select low without external access");

  property p_strobe_gate;
    issue && isInternal && sigOutDisableBit |=> readStrobeN &&
      writeStrobeLoN && writeStrobeHiN;
  endproperty
  a_strobe_gate: assert property (p_strobe_gate)
    else $error("strobe pulsed on internal access while disabled");

  property p_strobe_int;
    issue && !issueWrite && !sigOutDisableBit |=> !readStrobeN;
  endproperty
  a_strobe_int: assert property (p_strobe_int)
    else $error("read strobe missing with outputs enabled");

  property p_standby_rd;
    standbyActive && !$past(issue) |-> readStrobeN ==
      !$past(sigOutDisableBit && standbySelBit);
  endproperty
  a_standby_rd: assert property (p_standby_rd)
    else $error("standby read strobe level wrong");

  property p_clk_toggle;
    // Divider sits at zero through reset, so skip the first edge after it
    !sigOutDisableBit && $past(!sigOutDisableBit) && !$past(reset) |->
      busClkPinOut != $past(busClkPinOut) && busClkPinOe;
  endproperty
  a_clk_toggle: assert property (p_clk_toggle)
    else $error("bus clock not toggling");

  property p_clk_stop;
    sigOutDisableBit |-> busClkPinOut == busClkPortLatch;
  endproperty
  a_clk_stop: assert property (p_clk_stop)
    else $error("bus clock pin not driving latch");

  property p_vector;
    state_reg == ebcs_pkg::EBCS_VLO_CAP ##2
      state_reg == ebcs_pkg::EBCS_VHI_CAP |=> startValid &&
      startAddr == {ebcs_pkg::EBCS_VEC_BANK, $past(extReadData),
      $past(extReadData, 3)};
  endproperty
  a_vector: assert property (p_vector)
    else $error("start address assembled wrong");

  property p_mode;
    state_reg == ebcs_pkg::EBCS_IDLE && !modeSelectPin |=>
      !procModeActive ##1 !startValid [*4];
  endproperty
  a_mode: assert property (p_mode)
    else $error("started without mode pin high");

  property p_start_seq;
    state_reg == ebcs_pkg::EBCS_IDLE && modeSelectPin |->
      ##5 startValid && procModeActive;
  endproperty
  a_start_seq: assert property (p_start_seq)
    else $error("start sequence did not finish in five cycles");

endmodule // ebcs_ctrl

/* File: testbench/ebcs_ext_mem.sv */
// External memory model that answers the start vector reads
module ebcs_ext_mem #(
  parameter logic [7:0] VEC_LO = 8'h5A,
  parameter logic [7:0] VEC_HI = 8'hC3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic chipSel1N,
  input wire logic readStrobeN,
  output logic [7:0] extReadData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] readCount;
  logic [7:0] lastData;
  // Low byte first, then middle; a released bus never repeats old data
  always_comb begin
    if (!readStrobeN && !chipSel1N) begin
      extReadData = (readCount == 2'h0) ? VEC_LO : VEC_HI;
    end else begin
      extReadData = ~lastData;
    end
  end
  // Count served reads, saturating so later reads stay harmless
  always_ff @(posedge clk) begin
    if (reset) begin
      readCount <= 2'h0;
      lastData <= 8'h00;
    end else if (!readStrobeN && !chipSel1N) begin
      readCount <= (readCount == 2'h3) ? readCount : readCount + 2'h1;
      lastData <= extReadData;
    end
  end
endmodule // ebcs_ext_mem

/* File: testbench/ebcs_ctrl_tb.sv */
// Self-checking bench for the chip select controller
module ebcs_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] VL = 8'h5A;
  localparam logic [7:0] VH = 8'hC3;
  // Control bits: write, low lane, high lane, disable bit, byte mode
  typedef struct packed {
    logic [23:0] addr;
    logic [4:0] ctl;
    logic [7:0] exp;
  } ebcs_row_s;
  // Expected: chip selects 4..0, read, write low, write high
  localparam ebcs_row_s ROWS [15] = '{
    '{24'h000880, 5'h00, 8'hF3}, '{24'h00087F, 5'h00, 8'hFB},
    '{24'h00087F, 5'h02, 8'hFF}, '{24'h007FFF, 5'h18, 8'hF5},
    '{24'h008000, 5'h16, 8'hEE}, '{24'h03FFFF, 5'h02, 8'hEB},
    '{24'h040000, 5'h00, 8'hDB}, '{24'h07FFFF, 5'h1C, 8'hDC},
    '{24'h080000, 5'h00, 8'hBB}, '{24'h0BFFFF, 5'h02, 8'hBB},
    '{24'h0C0000, 5'h00, 8'h7B}, '{24'h0FFFFF, 5'h1D, 8'h7D},
    '{24'h100000, 5'h00, 8'hFB}, '{24'h000100, 5'h1E, 8'hFF},
    '{24'h000100, 5'h1C, 8'hFC}
  };
  logic clk, reset, modeSelectPin, byteModePin, sigOutDisableBit;
  logic standbySelBit, busClkPortLatch, busClkPortDir, waitInstruction;
  logic stopInstruction, wakeUp, accValid, accWrite, accLoByte, accHiByte;
  logic [23:0] accAddr, startAddr;
  logic [7:0] extReadData;
  logic accReady, chipSel0N, chipSel1N, chipSel2N, chipSel3N, chipSel4N;
  logic readStrobeN, writeStrobeLoN, writeStrobeHiN, busClkPinOut;
  logic busClkPinOe, startValid, procModeActive, standbyActive, b;
  int errCount = 0;
  int totalChecks = 0;
  wire logic [7:0] outs = {chipSel4N, chipSel3N, chipSel2N, chipSel1N,
    chipSel0N, readStrobeN, writeStrobeLoN, writeStrobeHiN};

  ebcs_ctrl i_dut (.clk(clk), .reset(reset), .modeSelectPin(modeSelectPin),
    .byteModePin(byteModePin), .sigOutDisableBit(sigOutDisableBit),
    .standbySelBit(standbySelBit), .busClkPortLatch(busClkPortLatch),
    .busClkPortDir(busClkPortDir), .waitInstruction(waitInstruction),
    .stopInstruction(stopInstruction), .wakeUp(wakeUp),
    .accValid(accValid), .accAddr(accAddr), .accWrite(accWrite),
    .accLoByte(accLoByte), .accHiByte(accHiByte),
    .extReadData(extReadData), .accReady(accReady),
    .chipSel0N(chipSel0N), .chipSel1N(chipSel1N), .chipSel2N(chipSel2N),
    .chipSel3N(chipSel3N), .chipSel4N(chipSel4N),
    .readStrobeN(readStrobeN), .writeStrobeLoN(writeStrobeLoN),
    .writeStrobeHiN(writeStrobeHiN), .busClkPinOut(busClkPinOut),
    .busClkPinOe(busClkPinOe), .startAddr(startAddr),
    .startValid(startValid), .procModeActive(procModeActive),
    .standbyActive(standbyActive));

  ebcs_ext_mem #(.VEC_LO(VL), .VEC_HI(VH)) i_mem (.clk(clk), .reset(reset),
    .chipSel1N(chipSel1N), .readStrobeN(readStrobeN),
    .extReadData(extReadData));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [23:0] e,
      input logic [23:0] g);
    totalChecks++;
    if (g !== e) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic printVerdict();
    $display("Checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Held four cycles; the outputs must already sit idle
  task automatic doReset(input logic mode);
    reset = 1'b1;
    modeSelectPin = mode;
    repeat (4) @(negedge clk);
    check("ready in reset", 24'h0, {23'h0, accReady});
    check("idle in reset", 24'hFF, {16'h0, outs});
    reset = 1'b0;
  endtask

  // Present one request, released after the edge that takes it
  task automatic access(input logic [23:0] a, input logic [4:0] c);
    accAddr = a;
    {accWrite, accLoByte, accHiByte, sigOutDisableBit, byteModePin} = c;
    accValid = 1'b1;
    @(negedge clk);
    accValid = 1'b0;
  endtask

  // Watchdog sized well above the expected run of under a hundred cycles
  initial begin
    #200000;
    errCount++;
    printVerdict();
  end

  initial begin
    {reset, modeSelectPin, byteModePin, sigOutDisableBit} = 4'hF;
    {standbySelBit, busClkPortLatch, busClkPortDir} = 3'h0;
    {waitInstruction, stopInstruction, wakeUp, accValid} = 4'h0;
    {accWrite, accLoByte, accHiByte, accAddr} = 27'h0;
    doReset(1'b1);
    repeat (4) @(negedge clk);
    check("start early", 24'h0, {23'h0, startValid});
    @(negedge clk);
    check("start valid", 24'h1, {23'h0, startValid});
    check("start addr", {8'h00, VH, VL}, startAddr);
    check("mode", 24'h1, {23'h0, procModeActive});
    $display("Test reset and start vector done");
    // Table of single accesses, each followed by an idle cycle
    for (int i = 0; i < 15; i++) begin
      check("ready", 24'h1, {23'h0, accReady});
      access(ROWS[i].addr, ROWS[i].ctl);
      check("strobes", {16'h0, ROWS[i].exp}, {16'h0, outs});
      @(negedge clk);
      check("idle", 24'hFF, {16'h0, outs});
    end
    $display("Test decode table done");
    // Back to back accesses must move the select in one cycle
    {accWrite, accLoByte, accHiByte, sigOutDisableBit, byteModePin} = 5'h00;
    accAddr = 24'h040000;
    accValid = 1'b1;
    @(negedge clk);
    accAddr = 24'h080000;
    check("first", 24'hDB, {16'h0, outs});
    @(negedge clk);
    accValid = 1'b0;
    check("second", 24'hBB, {16'h0, outs});
    @(negedge clk);
    check("idle after pair", 24'hFF, {16'h0, outs});
    $display("Test back to back done");
    // Wait and stop, with the disable bit clear and set
    for (int k = 0; k < 4; k++) begin
      sigOutDisableBit = k[1];
      standbySelBit = 1'b1;
      {stopInstruction, waitInstruction} = k[0] ? 2'h2 : 2'h1;
      @(negedge clk);
      {stopInstruction, waitInstruction} = 2'h0;
      @(negedge clk);
      check("standby", 24'h1, {23'h0, standbyActive});
      check("standby read", {23'h0, ~k[1]}, {23'h0, readStrobeN});
      check("ready in standby", 24'h0, {23'h0, accReady});
      wakeUp = 1'b1;
      @(negedge clk);
      wakeUp = 1'b0;
      @(negedge clk);
      check("woken", 24'h0, {23'h0, standbyActive});
      check("read after wake", 24'h1, {23'h0, readStrobeN});
    end
    // Wake in the same cycle as a wait must keep the block running
    waitInstruction = 1'b1;
    wakeUp = 1'b1;
    @(negedge clk);
    waitInstruction = 1'b0;
    wakeUp = 1'b0;
    check("wake wins", 24'h0, {23'h0, standbyActive});
    $display("Test standby done");
    // Bus clock pin: toggling, then frozen on the port latch
    sigOutDisableBit = 1'b0;
    @(negedge clk);
    b = busClkPinOut;
    @(negedge clk);
    check("bus clock toggles", {23'h0, ~b}, {23'h0, busClkPinOut});
    check("bus clock drive", 24'h1, {23'h0, busClkPinOe});
    sigOutDisableBit = 1'b1;
    busClkPortDir = 1'b1;
    for (int k = 0; k < 4; k++) begin
      busClkPortLatch = k[1];
      @(negedge clk);
      check("latch out", {23'h0, k[1]}, {23'h0, busClkPinOut});
      check("latch dir", 24'h1, {23'h0, busClkPinOe});
    end
    // Direction left as input must release the pin
    busClkPortDir = 1'b0;
    @(negedge clk);
    check("latch dir input", 24'h0, {23'h0, busClkPinOe});
    $display("Test bus clock done");
    // Mode pin low at release must never reach run
    doReset(1'b0);
    repeat (8) @(negedge clk);
    check("halt ready", 24'h0, {23'h0, accReady});
    check("halt start", 24'h0, {23'h0, startValid});
    check("halt mode", 24'h0, {23'h0, procModeActive});
    $display("Test mode pin low done");
    printVerdict();
  end
endmodule // ebcs_ctrl_tb
